// ### host_model.sv
// Host-side model: serial clock and shared data line
`timescale 1ns/10ps
`default_nettype none
module host_model (
    output logic      link_clk,
    output logic      sda_line,
    input  wire logic open_drain,
    input  wire logic dev_pull_low
);
    logic bit_q;
    logic drive_q;

    initial begin
        link_clk = 1'b0;
        bit_q    = 1'b1;
        drive_q  = 1'b0;
    end

    // ********
    // Line level
    // ********
    // Pull-up in open-drain mode; a released push-pull line shows the
    // inverse of its last bit so stale data never looks valid
    always_comb begin
        if (open_drain) begin
            sda_line = !((drive_q && !bit_q) || dev_pull_low);
        end else begin
            sda_line = drive_q ? bit_q : !bit_q;
        end
    end

    // ********
    // Frames
    // ********
    // One clock per bit within a frame, MSB first; pulses gives idle clocks outside frames
    task automatic send_word(input logic [7:0] w);
        for (int i = 7; i >= 0; i--) begin
            bit_q   = w[i];
            drive_q = 1'b1;
            #3 link_clk = 1'b1;
            #3 link_clk = 1'b0;
        end
        drive_q = 1'b0;
    endtask

    task automatic pulses(input int n);
        repeat (n) begin
            #3 link_clk = 1'b1;
            #3 link_clk = 1'b0;
        end
    endtask
endmodule
`default_nettype wire

// ### host_pin_control.sv
// Host-facing pin control: reset, trigger, ready flag, interface mux
`timescale 1ns/10ps
`default_nettype none
module host_pin_control
    import host_pin_pkg::*;
#(
    parameter int PULSE_CYC = READY_PULSE_CYC
) (
    input  wire logic                 clock,
    input  wire logic                 sys_rst,
    input  wire logic                 link_clk,
    input  wire logic                 reset_pin_n,
    input  wire logic                 convert_trigger_n,
    input  wire logic                 iface_sel_pin,
    input  wire logic                 serial_data_i,
    output logic                      serial_data_o,
    output logic                      serial_data_oe,
    input  wire logic                 slave_addr_bit0,
    input  wire logic                 slave_addr_bit1_i,
    output logic                      slave_addr_bit1_o,
    output logic                      slave_addr_bit1_oe,
    input  wire logic                 slave_addr_bit2,
    input  wire logic                 auto_mode,
    input  wire logic                 conv_done,
    input  wire logic                 cycle_done,
    input  wire logic                 data_read,
    input  wire logic                 tx_bit,
    input  wire logic                 sda_drive_low,
    output logic                      core_reset,
    output logic                      convert_start,
    output logic                      data_ready_n,
    output logic                      spi_selected,
    output logic                      i2c_selected,
    output logic                      spi_cs_active,
    output logic [2:0]                i2c_address,
    output logic [RX_WORD_W-1:0]      rx_word,
    output logic                      rx_valid
);

    // ***************************************************************
    // Pin synchronisers in the core domain
    // ***************************************************************
    logic [5:0] pins_sync;
    logic       rst_pin_s;
    logic       trig_s;
    logic       strap_s;
    logic       cs_s;
    logic       addr1_s;
    logic       addr2_s;

    sync2 #(.WIDTH(6), .RESET_VAL(1'b1)) u_pin_sync (
        .clock    (clock),
        .rst      (sys_rst),
        .async_in ({reset_pin_n, convert_trigger_n, iface_sel_pin,
                    slave_addr_bit0, slave_addr_bit1_i, slave_addr_bit2}),
        .sync_out (pins_sync)
    );

    assign {rst_pin_s, trig_s, strap_s, cs_s, addr1_s, addr2_s} = pins_sync;

    // ***************************************************************
    // Device reset and strap capture
    // ***************************************************************
    logic strap_done_q;
    logic spi_sel_q;
    logic trig_prev_q;

    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            core_reset <= 1'b1;
        end else begin
            core_reset <= ~rst_pin_s;
        end
    end

    // Strap is caught once after each reset release and then held
    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            strap_done_q <= 1'b0;
            spi_sel_q    <= STRAP_SPI;
        end else if (core_reset) begin
            strap_done_q <= 1'b0;
        end else if (!strap_done_q) begin
            strap_done_q <= 1'b1;
            spi_sel_q    <= (strap_s == STRAP_SPI);
        end
    end

    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            spi_selected <= 1'b0;
            i2c_selected <= 1'b0;
        end else begin
            spi_selected <= strap_done_q & ~core_reset & spi_sel_q;
            i2c_selected <= strap_done_q & ~core_reset & ~spi_sel_q;
        end
    end

    // ***************************************************************
    // Conversion trigger
    // ***************************************************************
    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            trig_prev_q   <= 1'b1;
            convert_start <= 1'b0;
        end else begin
            trig_prev_q   <= trig_s;
            convert_start <= trig_prev_q & ~trig_s & ~core_reset;
        end
    end

    // ***************************************************************
    // Data ready indicator
    // ***************************************************************
    ready_state_t              ready_q;
    logic [READY_CNT_W-1:0]    pulse_cnt_q;

    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            ready_q     <= READY_IDLE;
            pulse_cnt_q <= '0;
        end else if (core_reset) begin
            ready_q     <= READY_IDLE;
            pulse_cnt_q <= '0;
        end else if (auto_mode && cycle_done) begin
            ready_q     <= READY_PULSE;
            pulse_cnt_q <= READY_CNT_W'(PULSE_CYC - 1);
        end else if (!auto_mode && conv_done) begin
            ready_q     <= READY_HOLD;
        end else begin
            unique case (ready_q)
                READY_IDLE: begin
                    pulse_cnt_q <= '0;
                end
                READY_HOLD: begin
                    if (data_read) begin
                        ready_q <= READY_IDLE;
                    end
                end
                READY_PULSE: begin
                    if (pulse_cnt_q == '0) begin
                        ready_q <= READY_IDLE;
                    end else begin
                        pulse_cnt_q <= pulse_cnt_q - 1'b1;
                    end
                end
                default: begin
                    ready_q <= READY_IDLE;
                end
            endcase
        end
    end

    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            data_ready_n <= READY_N_IDLE;
        end else begin
            data_ready_n <= (ready_q == READY_IDLE);
        end
    end

    // ***************************************************************
    // Shared pin multiplexing
    // ***************************************************************
    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            serial_data_o      <= 1'b0;
            serial_data_oe     <= 1'b0;
            slave_addr_bit1_o  <= 1'b0;
            slave_addr_bit1_oe <= 1'b0;
            spi_cs_active      <= 1'b0;
            i2c_address        <= 3'h0;
        end else begin
            serial_data_o      <= 1'b0;
            serial_data_oe     <= i2c_selected & sda_drive_low;
            spi_cs_active      <= spi_selected & ~cs_s;
            slave_addr_bit1_o  <= tx_bit & spi_selected & ~cs_s;
            slave_addr_bit1_oe <= spi_selected & ~cs_s;
            if (i2c_selected) begin
                i2c_address <= {addr2_s, addr1_s, cs_s};
            end else begin
                i2c_address <= 3'h0;
            end
        end
    end

    // ***************************************************************
    // Link clock domain: word assembly on the host serial clock
    // ***************************************************************
    logic                 link_rst_meta_q;
    logic                 link_rst_q;
    logic                 link_run_s;
    logic                 link_run_q;
    logic [RX_CNT_W-1:0]  bit_cnt_q;
    logic [RX_WORD_W-1:0] shift_q;
    logic [RX_WORD_W-1:0] hold_q;
    logic                 word_tgl_q;

    assign link_run_q = spi_selected | i2c_selected;

    always_ff @(posedge link_clk or posedge sys_rst) begin
        if (sys_rst) begin
            link_rst_meta_q <= 1'b1;
            link_rst_q      <= 1'b1;
        end else begin
            link_rst_meta_q <= 1'b0;
            link_rst_q      <= link_rst_meta_q;
        end
    end

    sync2 #(.WIDTH(1), .RESET_VAL(1'b0)) u_run_sync (
        .clock    (link_clk),
        .rst      (link_rst_q),
        .async_in (link_run_q),
        .sync_out (link_run_s)
    );

    // Serial clock is only ever an input from the host
    always_ff @(posedge link_clk or posedge link_rst_q) begin
        if (link_rst_q) begin
            bit_cnt_q  <= '0;
            shift_q    <= RX_RESET;
            hold_q     <= RX_RESET;
            word_tgl_q <= 1'b0;
        end else if (!link_run_s) begin
            bit_cnt_q  <= '0;
        end else begin
            shift_q   <= {shift_q[RX_WORD_W-2:0], serial_data_i};
            bit_cnt_q <= bit_cnt_q + 1'b1;
            if (bit_cnt_q == '1) begin
                hold_q     <= {shift_q[RX_WORD_W-2:0], serial_data_i};
                word_tgl_q <= ~word_tgl_q;
            end
        end
    end

    // ***************************************************************
    // Word hand-over into the core domain
    // ***************************************************************
    logic tgl_s;
    logic tgl_prev_q;

    sync2 #(.WIDTH(1), .RESET_VAL(1'b0)) u_tgl_sync (
        .clock    (clock),
        .rst      (sys_rst),
        .async_in (word_tgl_q),
        .sync_out (tgl_s)
    );

    // Held word is stable for a whole word time after the toggle
    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            tgl_prev_q <= 1'b0;
            rx_valid   <= 1'b0;
            rx_word    <= RX_RESET;
        end else begin
            tgl_prev_q <= tgl_s;
            rx_valid   <= (tgl_s ^ tgl_prev_q) & link_run_q;
            if ((tgl_s ^ tgl_prev_q) && link_run_q) begin
                rx_word <= hold_q;
            end
        end
    end

    // ***************************************************************
    // Checks
    // ***************************************************************
    logic [READY_CNT_W-1:0] low_cnt_q;
    logic                   ready_req_q;

    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            low_cnt_q   <= '0;
            ready_req_q <= 1'b0;
        end else begin
            ready_req_q <= ~core_reset & (auto_mode ? cycle_done : conv_done);
            if (data_ready_n || ready_req_q) begin
                low_cnt_q <= '0;
            end else begin
                low_cnt_q <= low_cnt_q + 1'b1;
            end
        end
    end

    chk_reset_follows: assert property (
        @(posedge clock) disable iff (sys_rst)
        !rst_pin_s |=> core_reset ##2 (data_ready_n && !convert_start))
        else $error("Reset pin low did not reset the block");

    chk_direct_ready: assert property (
        @(posedge clock) disable iff (sys_rst)
        (!auto_mode && conv_done && !core_reset) |=> ##1 !data_ready_n)
        else $error("Direct mode ready did not go low");

    chk_pulse_width: assert property (
        @(posedge clock) disable iff (sys_rst || core_reset)
        (auto_mode && !cycle_done && $rose(data_ready_n)) |->
            ($past(low_cnt_q) == READY_CNT_W'(PULSE_CYC - 1)))
        else $error("Auto mode ready pulse has wrong width");

    chk_idle_high: assert property (
        @(posedge clock) disable iff (sys_rst)
        $fell(data_ready_n) |-> $past(ready_req_q))
        else $error("Ready output fell without a request");

    chk_trigger_edge: assert property (
        @(posedge clock) disable iff (sys_rst)
        convert_start |-> ($past(trig_s, 2) && !$past(trig_s)))
        else $error("Conversion start without trigger falling edge");

    chk_spi_only: assert property (
        @(posedge clock) disable iff (sys_rst)
        spi_selected |-> (!i2c_selected && !serial_data_oe
                          && i2c_address == 3'h0))
        else $error("I2C side active in SPI mode");

    chk_i2c_only: assert property (
        @(posedge clock) disable iff (sys_rst)
        i2c_selected |=> (!slave_addr_bit1_oe && !spi_cs_active))
        else $error("SPI side active in I2C mode");

    chk_addr_map: assert property (
        @(posedge clock) disable iff (sys_rst)
        i2c_selected |=> (i2c_address
            == {$past(addr2_s), $past(addr1_s), $past(cs_s)}))
        else $error("I2C address bits not taken from pins");

    chk_strap_static: assert property (
        @(posedge clock) disable iff (sys_rst || core_reset)
        (strap_done_q && $past(strap_done_q)) |-> $stable(spi_sel_q))
        else $error("Interface select changed without reset");

    cov_auto_pulse: cover property (
        @(posedge clock) disable iff (sys_rst)
        auto_mode && $rose(data_ready_n));

    cov_direct_read: cover property (
        @(posedge clock) disable iff (sys_rst)
        (ready_q == READY_HOLD) ##1 data_read ##2 data_ready_n);

    cov_word_rx: cover property (
        @(posedge clock) disable iff (sys_rst)
        rx_valid && i2c_selected);

    cov_trigger: cover property (
        @(posedge clock) disable iff (sys_rst)
        convert_start && spi_selected);

endmodule
`default_nettype wire

// ### host_pin_pkg.sv
// Shared constants for the host-facing pin logic
package host_pin_pkg;

    // ***************************************************************
    // Clock and timing
    // ***************************************************************
    localparam int CLK_MHZ          = 250;
    localparam int READY_PULSE_NS   = 1000;
    localparam int READY_PULSE_CYC  = (READY_PULSE_NS * CLK_MHZ) / 1000;
    localparam int READY_CNT_W      = 9;
    localparam int RESET_DELAY_US   = 250;

    // ***************************************************************
    // Interface select strap levels
    // ***************************************************************
    localparam logic STRAP_SPI      = 1'b1;
    localparam logic STRAP_I2C      = 1'b0;

    // ***************************************************************
    // Link word assembly
    // ***************************************************************
    localparam int RX_WORD_W        = 8;
    localparam int RX_CNT_W         = 3;

    // ***************************************************************
    // Reset values
    // ***************************************************************
    localparam logic READY_N_IDLE   = 1'b1;
    localparam logic [7:0] RX_RESET = 8'h00;

    typedef enum logic [1:0] {
        READY_IDLE,
        READY_HOLD,
        READY_PULSE
    } ready_state_t;

endpackage

// ### sync2.sv
// Two-flop level synchroniser
`timescale 1ns/10ps
`default_nettype none
module sync2 #(
    parameter int   WIDTH     = 1,
    parameter logic RESET_VAL = 1'b0
) (
    input  wire logic             clock,
    input  wire logic             rst,
    input  wire logic [WIDTH-1:0] async_in,
    output logic      [WIDTH-1:0] sync_out
);

    logic [WIDTH-1:0] meta_q;

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            meta_q   <= {WIDTH{RESET_VAL}};
            sync_out <= {WIDTH{RESET_VAL}};
        end else begin
            meta_q   <= async_in;
            sync_out <= meta_q;
        end
    end

endmodule
`default_nettype wire

// ### tb_top.sv
// Self-checking bench for the host pin control block
`timescale 1ns/10ps
`default_nettype none
module tb_top;
    import host_pin_pkg::*;
    localparam int PC = 10;
    logic clock, sys_rst, reset_pin_n, convert_trigger_n, iface_sel_pin;
    logic slave_addr_bit0, slave_addr_bit1_i, slave_addr_bit2, auto_mode;
    logic conv_done, cycle_done, data_read, tx_bit, sda_drive_low;
    wire logic link_clk, serial_data_i;
    logic serial_data_o, serial_data_oe, slave_addr_bit1_o;
    logic slave_addr_bit1_oe, core_reset, convert_start, data_ready_n;
    logic spi_selected, i2c_selected, spi_cs_active, rx_valid;
    logic [2:0] i2c_address;
    logic [7:0] rx_word;
    int bad_count;
    int comparisons;

    host_pin_control #(.PULSE_CYC(PC)) DUT (
        .clock, .sys_rst, .link_clk, .reset_pin_n, .convert_trigger_n,
        .iface_sel_pin, .serial_data_i, .serial_data_o, .serial_data_oe,
        .slave_addr_bit0, .slave_addr_bit1_i, .slave_addr_bit1_o,
        .slave_addr_bit1_oe, .slave_addr_bit2, .auto_mode, .conv_done,
        .cycle_done, .data_read, .tx_bit, .sda_drive_low, .core_reset,
        .convert_start, .data_ready_n, .spi_selected, .i2c_selected,
        .spi_cs_active, .i2c_address, .rx_word, .rx_valid
    );

    host_model host (
        .link_clk(link_clk), .sda_line(serial_data_i),
        .open_drain(!iface_sel_pin), .dev_pull_low(serial_data_oe)
    );

    always #2 clock = !clock;

    // ********
    // Helpers
    // ********
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        comparisons++;
        if (got !== exp) begin
            bad_count++;
            $display("wrong value at %0t: got %h expected %h",
                     $time, got, exp);
        end
    endtask

    task automatic cyc(input int n);
        repeat (n) @(posedge clock);
        #1;
    endtask

    // Two idle clocks let the select reach the link domain first
    task automatic recv(input logic [7:0] w);
        int n;
        n = 0;
        host.pulses(2);
        host.send_word(w);
        repeat (8) begin
            cyc(1);
            n += int'(rx_valid === 1'b1);
        end
        chk(8'(n), 8'h01);
        chk(rx_word, w);
    endtask

    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", comparisons, bad_count);
        if (bad_count == 0 && comparisons > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    task automatic pin_reset(input logic strap);
        @(posedge clock);
        reset_pin_n   <= 1'b0;
        iface_sel_pin <= strap;
        cyc(5);
        chk(core_reset, 1'b1);
        chk(spi_selected | i2c_selected, 1'b0);
        host.pulses(4);
        @(posedge clock);
        reset_pin_n <= 1'b1;
        cyc(10);
        chk(core_reset, 1'b0);
        chk(spi_selected, strap);
        chk(i2c_selected, !strap);
    endtask

    // ********
    // Scenarios
    // ********
    task automatic test_trigger();
        int n;
        n = 0;
        @(posedge clock);
        convert_trigger_n <= 1'b0;
        repeat (8) begin
            cyc(1);
            n += int'(convert_start === 1'b1);
        end
        @(posedge clock);
        convert_trigger_n <= 1'b1;
        repeat (8) begin
            cyc(1);
            n += int'(convert_start === 1'b1);
        end
        chk(8'(n), 8'h01);
        $display("test_trigger done");
    endtask

    task automatic test_direct();
        @(posedge clock);
        auto_mode <= 1'b0;
        conv_done <= 1'b1;
        @(posedge clock);
        conv_done <= 1'b0;
        cyc(20);
        chk(data_ready_n, 1'b0);
        @(posedge clock);
        data_read <= 1'b1;
        @(posedge clock);
        data_read <= 1'b0;
        cyc(4);
        chk(data_ready_n, 1'b1);
        $display("test_direct done");
    endtask

    task automatic test_auto();
        int n;
        n = 0;
        @(posedge clock);
        auto_mode  <= 1'b1;
        cycle_done <= 1'b1;
        @(posedge clock);
        cycle_done <= 1'b0;
        repeat (PC + 10) begin
            cyc(1);
            n += int'(data_ready_n === 1'b0);
        end
        chk(8'(n), 8'(PC));
        chk(data_ready_n, 1'b1);
        $display("test_auto done");
    endtask

    task automatic test_spi();
        pin_reset(1'b1);
        @(posedge clock);
        slave_addr_bit0 <= 1'b0;
        tx_bit          <= 1'b1;
        sda_drive_low   <= 1'b1;
        cyc(6);
        chk(spi_cs_active, 1'b1);
        chk({slave_addr_bit1_oe, slave_addr_bit1_o}, 8'h03);
        chk(serial_data_oe, 1'b0);
        chk(i2c_address, 3'h0);
        @(posedge clock);
        tx_bit <= 1'b0;
        cyc(2);
        chk(slave_addr_bit1_o, 1'b0);
        recv(8'hA5);
        @(posedge clock);
        slave_addr_bit0 <= 1'b1;
        sda_drive_low   <= 1'b0;
        cyc(6);
        chk({spi_cs_active, slave_addr_bit1_oe}, 8'h00);
        $display("test_spi done");
    endtask

    task automatic test_i2c();
        pin_reset(1'b0);
        for (int i = 0; i < 2; i++) begin
            @(posedge clock);
            {slave_addr_bit2, slave_addr_bit1_i, slave_addr_bit0}
                <= (i == 0) ? 3'h5 : 3'h2;
            cyc(6);
            chk(i2c_address, (i == 0) ? 3'h5 : 3'h2);
            chk({spi_cs_active, slave_addr_bit1_oe}, 8'h00);
        end
        chk(serial_data_oe, 1'b0);
        @(posedge clock);
        sda_drive_low <= 1'b0;
        cyc(4);
        recv(8'h3C);
        @(posedge clock);
        sda_drive_low <= 1'b1;
        cyc(4);
        chk({serial_data_oe, serial_data_o}, 8'h02);
        $display("test_i2c done");
    endtask

    initial begin
        #20000;
        bad_count++;
        report_and_stop();
    end

    initial begin
        clock = 1'b0; sys_rst = 1'b1; reset_pin_n = 1'b1;
        convert_trigger_n = 1'b1; iface_sel_pin = 1'b1; tx_bit = 1'b0;
        slave_addr_bit0 = 1'b1; slave_addr_bit1_i = 1'b0; auto_mode = 1'b0;
        slave_addr_bit2 = 1'b0; conv_done = 1'b0; cycle_done = 1'b0;
        data_read = 1'b0; sda_drive_low = 1'b0;
        bad_count = 0;
        comparisons = 0;
        // Link reset flops need a serial clock edge while reset is high
        fork
            host.pulses(1);
        join_none
        cyc(1);
        chk({core_reset, data_ready_n}, 8'h03);
        @(posedge clock);
        sys_rst <= 1'b0;
        pin_reset(1'b1);
        test_trigger();
        test_direct();
        test_auto();
        test_spi();
        test_i2c();
        report_and_stop();
    end
endmodule
`default_nettype wire
